// ### iapfc_defs.svh
// Register offsets, field positions, reset values and counts of the flash programming controller.
`ifndef IAPFC_DEFS_SVH
`define IAPFC_DEFS_SVH

// Byte offsets on the register bus, one aligned word each.
`define IAPFC_OFF_MAIN_CTRL   8'h00
`define IAPFC_OFF_CHIP_RST    8'h04
`define IAPFC_OFF_BUF_CLR     8'h08
`define IAPFC_OFF_ADDR_LO     8'h0c
`define IAPFC_OFF_ADDR_HI     8'h10
`define IAPFC_OFF_DATA0_LO    8'h14
`define IAPFC_DATA_STRIDE     8'h08
`define IAPFC_DATA_HI_STEP    8'h04

// Field positions in the main control register and the buffer clear register.
`define IAPFC_BIT_UNLOCKED    7
`define IAPFC_BIT_MODE_HI     6
`define IAPFC_BIT_MODE_LO     4
`define IAPFC_BIT_TRIGGER     3
`define IAPFC_BIT_WRITE_GO    2
`define IAPFC_BIT_READ_EN     1
`define IAPFC_BIT_READ_GO     0
`define IAPFC_BIT_CLEAR_GO    0

// Operation mode codes.
`define IAPFC_MODE_WRITE      3'h0
`define IAPFC_MODE_ERASE      3'h1
`define IAPFC_MODE_READ       3'h3
`define IAPFC_MODE_UNLOCK     3'h6

// Reset values and memory geometry.
`define IAPFC_RST_BYTE        8'h00
`define IAPFC_ADDR_BITS       13
`define IAPFC_OFFSET_BITS     5
`define IAPFC_PAGE_WORDS      32
`define IAPFC_LAST_OFFSET     5'h1f
`define IAPFC_ERASED_WORD     16'hffff

// Unlock window length in clock cycles.
`define IAPFC_UNLOCK_CYCLES   16'h0400

`endif

// ### iapfc_pkg.sv
// Types shared by the flash programming controller modules.
package iapfc_pkg;

	// Operation sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ERASE  = 3'b001,
		ST_WRITE  = 3'b010,
		ST_READ   = 3'b011,
		ST_FINISH = 3'b100,
		ST_CLEAR  = 3'b101
	} iapfc_state_type;

	// Which start bit the running operation belongs to.
	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_READ  = 2'b01,
		OP_CLEAR = 2'b10
	} iapfc_op_type;

	// One word loaded into the write buffer.
	typedef struct packed {
		logic        en;
		logic [4:0]  idx;
		logic [15:0] data;
	} iapfc_buf_load_type;

endpackage

// ### iapfc_wbuf.sv
// Page-sized write buffer with per-word valid flags and a one-cycle clear.
`timescale 1ns/1ns
`default_nettype none
`include "iapfc_defs.svh"

module iapfc_wbuf #(
	parameter int WORDS = `IAPFC_PAGE_WORDS
) (
	// Clock and reset.
	input  wire logic                        clk_in,
	input  wire logic                        rst_n_in,
	// Load and clear.
	input  wire iapfc_pkg::iapfc_buf_load_type load_in,
	input  wire logic                        clear_in,
	// Read port.
	input  wire logic [4:0]                  rd_idx_in,
	output logic      [15:0]                 rd_data_out,
	output logic                             rd_valid_out
);

	logic [15:0]      data_reg [0:WORDS-1];
	logic [WORDS-1:0] valid_reg;

	// Only valid words get programmed, so a cleared buffer leaves the page untouched.
	genvar g;
	generate
		for (g = 0; g < WORDS; g++) begin : g_entry
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					valid_reg[g] <= 1'b0;
				end else if (load_in.en && load_in.idx == 5'(g)) begin
					valid_reg[g] <= 1'b1;
				end else if (clear_in) begin
					valid_reg[g] <= 1'b0;
				end
			end

			// Data needs no reset; the valid flag guards it.
			always_ff @(posedge clk_in) begin
				if (load_in.en && load_in.idx == 5'(g)) begin
					data_reg[g] <= load_in.data;
				end
			end
		end
	endgenerate

	// Combinational read for the programming walk.
	assign rd_data_out  = data_reg[rd_idx_in];
	assign rd_valid_out = valid_reg[rd_idx_in];

	// A clear with no load leaves every word empty.
	buf_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		clear_in && !load_in.en |=> valid_reg == '0)
		else $error("write buffer not empty after clear");

	// A loaded word is marked valid.
	buf_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		load_in.en |=> valid_reg[$past(load_in.idx)])
		else $error("loaded word not marked valid");

endmodule
`default_nettype wire

// ### iapfc_top.sv
// In-application flash programming controller with a classic Wishbone register slave.
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "iapfc_defs.svh"

module iapfc_top #(
	parameter int          FLASH_WORDS   = 8192,
	parameter logic [15:0] UNLOCK_CYCLES = `IAPFC_UNLOCK_CYCLES,
	parameter logic [15:0] UNLOCK_PAT1   = 16'h1234, // arbitrary value
	parameter logic [15:0] UNLOCK_PAT2   = 16'h5678, // arbitrary value
	parameter logic [15:0] UNLOCK_PAT3   = 16'h9abc  // arbitrary value
) (
	// Clock and reset.
	input  wire logic        CLK_IN,
	input  wire logic        ARST_N_IN,
	// Wishbone slave.
	input  wire logic        WB_CYC_IN,
	input  wire logic        WB_STB_IN,
	input  wire logic        WB_WE_IN,
	input  wire logic [7:0]  WB_ADR_IN,
	input  wire logic [31:0] WB_DAT_IN,
	input  wire logic [3:0]  WB_SEL_IN,
	output logic             WB_ACK_OUT,
	output logic      [31:0] WB_DAT_OUT,
	// Processor stall.
	output logic             CPU_HALT_OUT
);

	logic                      rst_meta_reg;
	logic                      rst_n;
	logic                      ack_reg;
	logic [31:0]               rdat_reg;
	logic                      halt_reg;
	logic [2:0]                mode_reg;
	logic                      unlocked_reg;
	logic                      trig_reg;
	logic                      wgo_reg;
	logic                      ren_reg;
	logic                      rgo_reg;
	logic                      clrgo_reg;
	logic [7:0]                chip_rst_reg;
	logic [12:0]               addr_reg;
	logic [15:0]               timer_reg;
	logic [7:0]                dlo_reg [0:3];
	logic [7:0]                dhi_reg [0:3];
	logic [4:0]                idx_reg;
	logic [15:0]               flash_mem [0:FLASH_WORDS-1];
	iapfc_pkg::iapfc_state_type state_reg;
	iapfc_pkg::iapfc_op_type    op_reg;
	iapfc_pkg::iapfc_buf_load_type buf_load;
	logic                      wr_fire;
	logic                      wr_main;
	logic                      wr_clr;
	logic                      wr_chip;
	logic                      wr_alo;
	logic                      wr_ahi;
	logic [3:0]                wr_dlo;
	logic [3:0]                wr_dhi;
	logic                      unlock_match;
	logic                      buf_clear;
	logic [15:0]               buf_data;
	logic                      buf_valid;
	logic [12:0]               op_addr;
	logic [15:0]               rd_word;
	logic [31:0]               rd_mux;

	// Reset release goes through two flops so it leaves the async domain cleanly.
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// Bus handshake: ack one cycle after the request, dropped the cycle after.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= WB_CYC_IN && WB_STB_IN && !ack_reg;
			if (WB_CYC_IN && WB_STB_IN && !ack_reg) begin
				rdat_reg <= rd_mux;
			end
		end
	end

	// Writes take effect on the edge where ack is seen, with byte lane 0 enabled.
	assign wr_fire = WB_CYC_IN && WB_STB_IN && WB_WE_IN && ack_reg && WB_SEL_IN[0];
	assign wr_main = wr_fire && WB_ADR_IN == `IAPFC_OFF_MAIN_CTRL;
	assign wr_chip = wr_fire && WB_ADR_IN == `IAPFC_OFF_CHIP_RST;
	assign wr_clr  = wr_fire && WB_ADR_IN == `IAPFC_OFF_BUF_CLR;
	assign wr_alo  = wr_fire && WB_ADR_IN == `IAPFC_OFF_ADDR_LO;
	assign wr_ahi  = wr_fire && WB_ADR_IN == `IAPFC_OFF_ADDR_HI;

	// Read decode; unmapped offsets answer zero, bits above the byte read zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (WB_ADR_IN == `IAPFC_OFF_MAIN_CTRL) begin
			rd_mux[7:0] = {unlocked_reg, mode_reg, trig_reg, wgo_reg, ren_reg, rgo_reg};
		end else if (WB_ADR_IN == `IAPFC_OFF_CHIP_RST) begin
			rd_mux[7:0] = chip_rst_reg;
		end else if (WB_ADR_IN == `IAPFC_OFF_BUF_CLR) begin
			rd_mux[0] = clrgo_reg;
		end else if (WB_ADR_IN == `IAPFC_OFF_ADDR_LO) begin
			rd_mux[7:0] = addr_reg[7:0];
		end else if (WB_ADR_IN == `IAPFC_OFF_ADDR_HI) begin
			rd_mux[4:0] = addr_reg[12:8];
		end else begin
			for (int n = 0; n < 4; n++) begin
				if (WB_ADR_IN == 8'(`IAPFC_OFF_DATA0_LO + n * `IAPFC_DATA_STRIDE)) begin
					rd_mux[7:0] = dlo_reg[n];
				end
				if (WB_ADR_IN == 8'(`IAPFC_OFF_DATA0_LO + n * `IAPFC_DATA_STRIDE
					+ `IAPFC_DATA_HI_STEP)) begin
					rd_mux[7:0] = dhi_reg[n];
				end
			end
		end
	end

	// Data register pairs; pair 0 also receives the word of a finished read.
	genvar p;
	generate
		for (p = 0; p < 4; p++) begin : g_pair
			assign wr_dlo[p] = wr_fire
				&& WB_ADR_IN == 8'(`IAPFC_OFF_DATA0_LO + p * `IAPFC_DATA_STRIDE);
			assign wr_dhi[p] = wr_fire
				&& WB_ADR_IN == 8'(`IAPFC_OFF_DATA0_LO + p * `IAPFC_DATA_STRIDE
				+ `IAPFC_DATA_HI_STEP);
			always_ff @(posedge CLK_IN or negedge rst_n) begin
				if (!rst_n) begin
					dlo_reg[p] <= `IAPFC_RST_BYTE;
					dhi_reg[p] <= `IAPFC_RST_BYTE;
				end else if (p == 0 && state_reg == iapfc_pkg::ST_READ) begin
					dlo_reg[p] <= rd_word[7:0];
					dhi_reg[p] <= rd_word[15:8];
				end else begin
					if (wr_dlo[p]) begin
						dlo_reg[p] <= WB_DAT_IN[7:0];
					end
					if (wr_dhi[p]) begin
						dhi_reg[p] <= WB_DAT_IN[7:0];
					end
				end
			end
		end
	endgenerate

	// A high-byte write to pair 0 loads the whole word while unlocked and idle.
	assign buf_load.en   = wr_dhi[0] && unlocked_reg
		&& state_reg == iapfc_pkg::ST_IDLE;
	assign buf_load.idx  = addr_reg[4:0];
	assign buf_load.data = {WB_DAT_IN[7:0], dlo_reg[0]};

	// Address pair; loads step the in-page offset and stop at its last word.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg <= 13'h0000;
		end else if (wr_alo) begin
			addr_reg[7:0] <= WB_DAT_IN[7:0];
		end else if (wr_ahi) begin
			addr_reg[12:8] <= WB_DAT_IN[4:0];
		end else if (buf_load.en && addr_reg[4:0] != `IAPFC_LAST_OFFSET) begin
			addr_reg[4:0] <= addr_reg[4:0] + 5'h01;
		end
	end

	// Unlock succeeds when, in unlock mode, the three patterns are present during the window.
	assign unlock_match = trig_reg && mode_reg == `IAPFC_MODE_UNLOCK
		&& {dhi_reg[1], dlo_reg[1]} == UNLOCK_PAT1
		&& {dhi_reg[2], dlo_reg[2]} == UNLOCK_PAT2
		&& {dhi_reg[3], dlo_reg[3]} == UNLOCK_PAT3;

	// Unlock window timer; the trigger bit falls when it runs out.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			timer_reg <= 16'h0000;
			trig_reg  <= 1'b0;
		end else if (wr_main && WB_DAT_IN[`IAPFC_BIT_TRIGGER]) begin
			timer_reg <= UNLOCK_CYCLES;
			trig_reg  <= 1'b1;
		end else if (timer_reg != 16'h0000) begin
			timer_reg <= timer_reg - 16'h0001;
			trig_reg  <= timer_reg != 16'h0001;
		end
	end

	// Unlocked flag: hardware set beats a software clear, software 1 does nothing.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			unlocked_reg <= 1'b0;
		end else if (unlock_match) begin
			unlocked_reg <= 1'b1;
		end else if (wr_main && !WB_DAT_IN[`IAPFC_BIT_UNLOCKED]) begin
			unlocked_reg <= 1'b0;
		end
	end

	// Mode, read enable and chip reset pattern are plain storage.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg     <= 3'h0;
			ren_reg      <= 1'b0;
			chip_rst_reg <= `IAPFC_RST_BYTE;
		end else begin
			if (wr_main) begin
				mode_reg <= WB_DAT_IN[`IAPFC_BIT_MODE_HI:`IAPFC_BIT_MODE_LO];
				ren_reg  <= WB_DAT_IN[`IAPFC_BIT_READ_EN];
			end
			if (wr_chip) begin
				chip_rst_reg <= WB_DAT_IN[7:0];
			end
		end
	end

	// Start bits: software sets, the sequencer clears on finish; a set wins.
	// If write and read are set together only the write is taken.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			wgo_reg   <= 1'b0;
			rgo_reg   <= 1'b0;
			clrgo_reg <= 1'b0;
		end else begin
			if (wr_main && WB_DAT_IN[`IAPFC_BIT_WRITE_GO]) begin
				wgo_reg <= 1'b1;
			end else if (state_reg == iapfc_pkg::ST_FINISH && op_reg == iapfc_pkg::OP_WRITE) begin
				wgo_reg <= 1'b0;
			end
			if (wr_main && WB_DAT_IN[`IAPFC_BIT_READ_GO] && !WB_DAT_IN[`IAPFC_BIT_WRITE_GO]) begin
				rgo_reg <= 1'b1;
			end else if (state_reg == iapfc_pkg::ST_FINISH && op_reg == iapfc_pkg::OP_READ) begin
				rgo_reg <= 1'b0;
			end
			if (wr_clr && WB_DAT_IN[`IAPFC_BIT_CLEAR_GO]) begin
				clrgo_reg <= 1'b1;
			end else if (state_reg == iapfc_pkg::ST_FINISH && op_reg == iapfc_pkg::OP_CLEAR) begin
				clrgo_reg <= 1'b0;
			end
		end
	end

	// Operation sequencer; a refused start passes straight to finish.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= iapfc_pkg::ST_IDLE;
			op_reg    <= iapfc_pkg::OP_WRITE;
			idx_reg   <= 5'h00;
		end else begin
			case (state_reg)
				iapfc_pkg::ST_IDLE: begin
					idx_reg <= 5'h00;
					if (wgo_reg) begin
						op_reg <= iapfc_pkg::OP_WRITE;
						if (unlocked_reg && mode_reg == `IAPFC_MODE_WRITE) begin
							state_reg <= iapfc_pkg::ST_WRITE;
						end else if (unlocked_reg && mode_reg == `IAPFC_MODE_ERASE) begin
							state_reg <= iapfc_pkg::ST_ERASE;
						end else begin
							state_reg <= iapfc_pkg::ST_FINISH;
						end
					end else if (rgo_reg) begin
						op_reg <= iapfc_pkg::OP_READ;
						if (ren_reg && mode_reg == `IAPFC_MODE_READ) begin
							state_reg <= iapfc_pkg::ST_READ;
						end else begin
							state_reg <= iapfc_pkg::ST_FINISH;
						end
					end else if (clrgo_reg) begin
						op_reg    <= iapfc_pkg::OP_CLEAR;
						state_reg <= iapfc_pkg::ST_CLEAR;
					end
				end
				iapfc_pkg::ST_ERASE, iapfc_pkg::ST_WRITE: begin
					idx_reg <= idx_reg + 5'h01;
					if (idx_reg == `IAPFC_LAST_OFFSET) begin
						state_reg <= iapfc_pkg::ST_FINISH;
					end
				end
				iapfc_pkg::ST_READ, iapfc_pkg::ST_CLEAR: begin
					state_reg <= iapfc_pkg::ST_FINISH;
				end
				default: begin
					state_reg <= iapfc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Page walk address: page from bits 12 to 5, offset from the walk counter.
	assign op_addr = {addr_reg[12:5], idx_reg};
	assign rd_word = flash_mem[addr_reg];

	// Flash array; erase fills the page, write programs only loaded words.
	always_ff @(posedge CLK_IN) begin
		if (state_reg == iapfc_pkg::ST_ERASE) begin
			flash_mem[op_addr] <= `IAPFC_ERASED_WORD;
		end else if (state_reg == iapfc_pkg::ST_WRITE && buf_valid) begin
			flash_mem[op_addr] <= buf_data;
		end
	end

	// Buffer clears on request and at the last word of a page write.
	assign buf_clear = state_reg == iapfc_pkg::ST_CLEAR
		|| (state_reg == iapfc_pkg::ST_WRITE && idx_reg == `IAPFC_LAST_OFFSET);

	iapfc_wbuf #(
		.WORDS (`IAPFC_PAGE_WORDS)
	) u_wbuf (
		.clk_in       (CLK_IN),
		.rst_n_in     (rst_n),
		.load_in      (buf_load),
		.clear_in     (buf_clear),
		.rd_idx_in    (idx_reg),
		.rd_data_out  (buf_data),
		.rd_valid_out (buf_valid)
	);

	// The stall follows the write and read start bits one cycle later, since outputs are registered.
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			halt_reg <= 1'b0;
		end else begin
			halt_reg <= wgo_reg || rgo_reg;
		end
	end

	assign WB_ACK_OUT   = ack_reg;
	assign WB_DAT_OUT   = rdat_reg;
	assign CPU_HALT_OUT = halt_reg;

	halt_tracks_go_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		halt_reg == $past(wgo_reg || rgo_reg))
		else $error("halt does not follow start bits");
	unlock_by_hw_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		$rose(unlocked_reg) |-> $past(unlock_match))
		else $error("unlocked set without pattern match");
	load_needs_unlock_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		buf_load.en |-> unlocked_reg)
		else $error("buffer load while locked");
	addr_step_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		buf_load.en && addr_reg[4:0] != 5'h1f |=> addr_reg == $past(addr_reg) + 13'h0001)
		else $error("address did not step after load");
	addr_hold_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		buf_load.en && addr_reg[4:0] == 5'h1f |=> $stable(addr_reg))
		else $error("address moved past last word");
	write_done_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		state_reg == iapfc_pkg::ST_WRITE && idx_reg == 5'h1f |-> ##2 !wgo_reg)
		else $error("write start bit not cleared");
	write_length_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		$rose(state_reg == iapfc_pkg::ST_WRITE) |-> (state_reg == iapfc_pkg::ST_WRITE)[*8])
		else $error("page write ended early");
	read_done_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		$rose(rgo_reg) |-> ##[1:4] !rgo_reg)
		else $error("read start bit not cleared");
	read_result_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		state_reg == iapfc_pkg::ST_READ |=> {dhi_reg[0], dlo_reg[0]} == $past(rd_word))
		else $error("read word not in data0 pair");
	clear_done_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		$rose(clrgo_reg) && !wgo_reg && !rgo_reg |-> ##[2:3] !clrgo_reg)
		else $error("clear start bit not cleared");
	high_zero_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		ack_reg |-> rdat_reg[31:8] == 24'h000000)
		else $error("upper read bits not zero");

	unlock_seen_c: cover property (@(posedge CLK_IN) disable iff (!rst_n) $rose(unlocked_reg));
	write_seen_c:  cover property (@(posedge CLK_IN) disable iff (!rst_n) $fell(wgo_reg));
	read_seen_c:   cover property (@(posedge CLK_IN) disable iff (!rst_n) state_reg == iapfc_pkg::ST_READ);
	hold_seen_c:   cover property (@(posedge CLK_IN) disable iff (!rst_n)
		buf_load.en && addr_reg[4:0] == 5'h1f);

endmodule
`default_nettype wire

// ### iapfc_top_tb.sv
// Self-checking testbench of the flash programming controller, driven over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "iapfc_defs.svh"

module iapfc_top_tb;
	localparam logic [7:0]  MC = `IAPFC_OFF_MAIN_CTRL;
	localparam logic [7:0]  BC = `IAPFC_OFF_BUF_CLR;
	localparam logic [7:0]  AL = `IAPFC_OFF_ADDR_LO;
	localparam logic [7:0]  AH = `IAPFC_OFF_ADDR_HI;
	localparam logic [7:0]  DL = `IAPFC_OFF_DATA0_LO;
	localparam logic [7:0]  DH = DL + `IAPFC_DATA_HI_STEP;
	// Unlock patterns for data pairs one to three; the values are arbitrary.
	localparam logic [15:0] PAT [1:3] = '{16'h2468, 16'h1357, 16'hace0};

	logic        clk;
	logic        arst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        ack;
	logic        halt;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [3:0]  sel;
	logic [7:0]  rd;
	int          fails;
	int          compares;

	// The unlock window is shortened so that its timeout fits a short run.
	iapfc_top #(
		.UNLOCK_CYCLES(16'h0010),
		.UNLOCK_PAT1  (PAT[1]),
		.UNLOCK_PAT2  (PAT[2]),
		.UNLOCK_PAT3  (PAT[3])
	) i_dut (
		.CLK_IN      (clk),
		.ARST_N_IN   (arst_n),
		.WB_CYC_IN   (cyc),
		.WB_STB_IN   (stb),
		.WB_WE_IN    (we),
		.WB_ADR_IN   (adr),
		.WB_DAT_IN   (wdat),
		.WB_SEL_IN   (sel),
		.WB_ACK_OUT  (ack),
		.WB_DAT_OUT  (rdat),
		.CPU_HALT_OUT(halt)
	);

	// Free-running clock with a 4 ns period.
	initial clk = 1'b0;
	always #2 clk = ~clk;

	// Compares a register or flash word.
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Compares the processor halt output.
	task automatic checkb(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic cycle; the request stands until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d, rd);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00, rd);
		check({8'h00, rd}, {8'h00, exp});
	endtask

	// Waits, with a bounded count of reads, for a self-clearing bit to drop.
	task automatic poll(input logic [7:0] a, input int b);
		for (int i = 0; i < 100; i++) begin
			wb(1'b0, a, 8'h00, rd);
			if (rd[b] !== 1'b1) break;
		end
		check({15'h0000, rd[b]}, 16'h0000);
	endtask

	// Reads one flash word through the data0 pair.
	task automatic rdword(input logic [7:0] a, input logic [15:0] exp);
		logic [7:0] lo;
		wr(AL, a);
		wr(MC, 8'hb3);
		poll(MC, 0);
		wb(1'b0, DL, 8'h00, lo);
		wb(1'b0, DH, 8'h00, rd);
		check({rd, lo}, exp);
	endtask

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// A hang is cut short well beyond the few hundred cycles the tests need.
	initial begin
		#80000;
		fails++;
		results();
	end

	// Main sequence.
	initial begin
		arst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h00000000;
		sel = 4'hf;
		fails = 0;
		compares = 0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		checkb(halt, 1'b0);
		for (int a = 0; a <= 'h34; a += 4) rdchk(8'(a), 8'h00);
		wr(8'h34, 8'h5a);
		rdchk(8'h34, 8'h00);
		wr(AH, 8'hff);
		rdchk(AH, 8'h1f);
		wr(AH, 8'h00);
		wr(MC, 8'h80);
		rdchk(MC, 8'h00);
		// A load while locked keeps the byte but does not move the address.
		wr(AL, 8'h05);
		wr(DL, 8'haa);
		wr(DH, 8'hbb);
		rdchk(DH, 8'hbb);
		rdchk(AL, 8'h05);
		// Unlock, then let the window time out.
		for (int i = 1; i < 4; i++) begin
			wr(8'(DL + 8 * i), PAT[i][7:0]);
			wr(8'(DH + 8 * i), PAT[i][15:8]);
		end
		wr(MC, 8'h68);
		rdchk(MC, 8'he8);
		repeat (40) @(posedge clk);
		rdchk(MC, 8'he0);
		// Erase page one; the low five address bits must not matter.
		wr(AL, 8'h25);
		wr(MC, 8'h94);
		repeat (2) @(posedge clk);
		checkb(halt, 1'b1);
		poll(MC, 2);
		wr(BC, 8'h01);
		poll(BC, 0);
		// Two loads at the end of the page; the second one must not wrap.
		wr(AL, 8'h3e);
		wr(DL, 8'h34);
		rdchk(AL, 8'h3e);
		wr(DH, 8'h12);
		rdchk(AL, 8'h3f);
		wr(DL, 8'h78);
		wr(DH, 8'h56);
		rdchk(AL, 8'h3f);
		wr(MC, 8'h84);
		poll(MC, 2);
		repeat (2) @(posedge clk);
		checkb(halt, 1'b0);
		rdword(8'h3e, 16'h1234);
		rdword(8'h3f, 16'h5678);
		rdword(8'h20, 16'hffff);
		// Erase again, then write with nothing loaded: the page must stay blank.
		wr(AL, 8'h20);
		wr(MC, 8'h94);
		poll(MC, 2);
		wr(MC, 8'h84);
		poll(MC, 2);
		rdword(8'h3e, 16'hffff);
		// A read with a reserved mode and no read enable is refused and leaves data0 alone.
		wr(MC, 8'h71);
		poll(MC, 0);
		rdchk(DL, 8'hff);
		results();
	end
endmodule
`default_nettype wire
